// ---- rtl/pic_ctrl.sv ----
// module: four-level prioritised interrupt controller beside the core sequencer
`timescale 1ns/10ps
module pic_ctrl (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire pic_pkg::pic_flags_t flags_in,
    input wire logic ext0_edge_in,
    input wire logic ext1_edge_in,
    input wire logic last_cycle_in,
    input wire logic irq_exit_instr_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    output logic mcycle_tick_out,
    output logic irq_call_out,
    output logic [15:0] vector_addr_out,
    output logic [3:0] in_service_out,
    output pic_pkg::pic_clr_t flag_clr_out
);

    //******************************************************************
    // reset release
    //******************************************************************
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    //******************************************************************
    // machine cycle divider
    //******************************************************************
    logic [1:0] mc_cnt_q;
    logic tick_q;

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mc_cnt_q <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            mc_cnt_q <= (mc_cnt_q == pic_pkg::MCYCLE_LAST) ? 2'h0 : mc_cnt_q + 2'h1;
            tick_q <= (mc_cnt_q == pic_pkg::MCYCLE_LAST);
        end
    end

    //******************************************************************
    // registers
    //******************************************************************
    logic [7:0] en_main_q;
    logic [7:0] en_aux_q;
    logic [7:0] plo0_q;
    logic [7:0] phi0_q;
    logic [5:0] plo1_q;
    logic [5:0] phi1_q;
    logic irq_reg_wr;

    function automatic logic is_irq_reg(input logic [7:0] a);
        is_irq_reg = (a == pic_pkg::ADDR_IRQ_EN_MAIN) || (a == pic_pkg::ADDR_IRQ_EN_AUX) ||
                     (a == pic_pkg::ADDR_PRIO_LOW_G0) || (a == pic_pkg::ADDR_PRIO_HIGH_G0) ||
                     (a == pic_pkg::ADDR_PRIO_LOW_G1) || (a == pic_pkg::ADDR_PRIO_HIGH_G1);
    endfunction

    assign irq_reg_wr = sfr_wr_in && is_irq_reg(sfr_addr_in);

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            en_main_q <= pic_pkg::REG_RESET;
            en_aux_q <= pic_pkg::REG_RESET;
            plo0_q <= pic_pkg::REG_RESET;
            phi0_q <= pic_pkg::REG_RESET;
            plo1_q <= pic_pkg::REG_RESET[5:0];
            phi1_q <= pic_pkg::REG_RESET[5:0];
        end else if (sfr_wr_in) begin
            case (sfr_addr_in)
                pic_pkg::ADDR_IRQ_EN_MAIN: en_main_q <= sfr_wdata_in; // R1 R2
                pic_pkg::ADDR_IRQ_EN_AUX: en_aux_q <= sfr_wdata_in;
                pic_pkg::ADDR_PRIO_LOW_G0: plo0_q <= sfr_wdata_in;
                pic_pkg::ADDR_PRIO_HIGH_G0: phi0_q <= sfr_wdata_in;
                pic_pkg::ADDR_PRIO_LOW_G1: plo1_q <= sfr_wdata_in[5:0]; // R5
                pic_pkg::ADDR_PRIO_HIGH_G1: phi1_q <= sfr_wdata_in[5:0]; // R4
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_out <= pic_pkg::RD_UNIMPL;
            sfr_hit_out <= 1'b0;
        end else if (sfr_rd_in) begin
            sfr_hit_out <= is_irq_reg(sfr_addr_in);
            case (sfr_addr_in)
                pic_pkg::ADDR_IRQ_EN_MAIN: sfr_rdata_out <= en_main_q;
                pic_pkg::ADDR_IRQ_EN_AUX: sfr_rdata_out <= en_aux_q;
                pic_pkg::ADDR_PRIO_LOW_G0: sfr_rdata_out <= plo0_q;
                pic_pkg::ADDR_PRIO_HIGH_G0: sfr_rdata_out <= phi0_q;
                pic_pkg::ADDR_PRIO_LOW_G1: sfr_rdata_out <= pic_pkg::G1_RSVD_MASK | {2'h0, plo1_q}; // R5
                pic_pkg::ADDR_PRIO_HIGH_G1: sfr_rdata_out <= pic_pkg::G1_RSVD_MASK | {2'h0, phi1_q}; // R4
                default: sfr_rdata_out <= pic_pkg::RD_UNIMPL;
            endcase
        end else begin
            sfr_hit_out <= 1'b0;
        end
    end

    //******************************************************************
    // per-source request, enable and level
    //******************************************************************
    logic [12:0] req;
    logic [12:0] en;
    logic [12:0] hi;
    logic [12:0] lo;

    always_comb begin
        req = '0;
        req[pic_pkg::SRC_EXT0] = flags_in.ext0_irq_flag;
        req[pic_pkg::SRC_BOD] = flags_in.brownout_flag;
        req[pic_pkg::SRC_WDT] = flags_in.watchdog_irq_flag;
        req[pic_pkg::SRC_TMR0] = flags_in.timer0_overflow_flag;
        req[pic_pkg::SRC_TWI] = flags_in.twowire_flag;
        req[pic_pkg::SRC_ADC] = flags_in.converter_done_flag;
        req[pic_pkg::SRC_EXT1] = flags_in.ext1_irq_flag;
        req[pic_pkg::SRC_KBD] = flags_in.keypad_flag;
        req[pic_pkg::SRC_CMP1] = flags_in.comparator1_flag;
        req[pic_pkg::SRC_TMR1] = flags_in.timer1_overflow_flag;
        req[pic_pkg::SRC_CMP2] = flags_in.comparator2_flag;
        req[pic_pkg::SRC_UART] = flags_in.uart_rx_done_flag | flags_in.uart_tx_done_flag;
        req[pic_pkg::SRC_PWM] = flags_in.pwm_brake_flag;
    end

    always_comb begin
        en = '0;
        hi = '0;
        lo = '0;
        // R2
        en[pic_pkg::SRC_EXT0] = en_main_q[0];
        en[pic_pkg::SRC_TMR0] = en_main_q[1];
        en[pic_pkg::SRC_EXT1] = en_main_q[2];
        en[pic_pkg::SRC_TMR1] = en_main_q[3];
        en[pic_pkg::SRC_UART] = en_main_q[4];
        en[pic_pkg::SRC_BOD] = en_main_q[5];
        en[pic_pkg::SRC_ADC] = en_main_q[6];
        en[pic_pkg::SRC_TWI] = en_aux_q[0];
        en[pic_pkg::SRC_KBD] = en_aux_q[1];
        en[pic_pkg::SRC_CMP1] = en_aux_q[2];
        en[pic_pkg::SRC_CMP2] = en_aux_q[3];
        en[pic_pkg::SRC_WDT] = en_aux_q[4];
        en[pic_pkg::SRC_PWM] = en_aux_q[5];
        hi[pic_pkg::SRC_EXT0] = phi0_q[0];
        hi[pic_pkg::SRC_TMR0] = phi0_q[1];
        hi[pic_pkg::SRC_EXT1] = phi0_q[2];
        hi[pic_pkg::SRC_TMR1] = phi0_q[3];
        hi[pic_pkg::SRC_UART] = phi0_q[4];
        hi[pic_pkg::SRC_BOD] = phi0_q[5];
        hi[pic_pkg::SRC_ADC] = phi0_q[6];
        lo[pic_pkg::SRC_EXT0] = plo0_q[0];
        lo[pic_pkg::SRC_TMR0] = plo0_q[1];
        lo[pic_pkg::SRC_EXT1] = plo0_q[2];
        lo[pic_pkg::SRC_TMR1] = plo0_q[3];
        lo[pic_pkg::SRC_UART] = plo0_q[4];
        lo[pic_pkg::SRC_BOD] = plo0_q[5];
        lo[pic_pkg::SRC_ADC] = plo0_q[6];
        // R4 R5
        hi[pic_pkg::SRC_TWI] = phi1_q[0];
        hi[pic_pkg::SRC_KBD] = phi1_q[1];
        hi[pic_pkg::SRC_CMP1] = phi1_q[2];
        hi[pic_pkg::SRC_CMP2] = phi1_q[3];
        hi[pic_pkg::SRC_WDT] = phi1_q[4];
        hi[pic_pkg::SRC_PWM] = phi1_q[5];
        lo[pic_pkg::SRC_TWI] = plo1_q[0];
        lo[pic_pkg::SRC_KBD] = plo1_q[1];
        lo[pic_pkg::SRC_CMP1] = plo1_q[2];
        lo[pic_pkg::SRC_CMP2] = plo1_q[3];
        lo[pic_pkg::SRC_WDT] = plo1_q[4];
        lo[pic_pkg::SRC_PWM] = plo1_q[5];
    end

    //******************************************************************
    // resolution
    //******************************************************************
    function automatic logic [15:0] vec_of(input logic [3:0] s);
        case (s) // R17
            4'h0: vec_of = 16'h0003;
            4'h1: vec_of = 16'h002b;
            4'h2: vec_of = 16'h0053;
            4'h3: vec_of = 16'h000b;
            4'h4: vec_of = 16'h0033;
            4'h5: vec_of = 16'h005b;
            4'h6: vec_of = 16'h0013;
            4'h7: vec_of = 16'h003b;
            4'h8: vec_of = 16'h0063;
            4'h9: vec_of = 16'h001b;
            4'ha: vec_of = 16'h0043;
            4'hb: vec_of = 16'h0023;
            4'hc: vec_of = 16'h0073;
            default: vec_of = 16'h0000;
        endcase
    endfunction

    logic [3:0] isr_q;
    logic win_found;
    logic [3:0] win_src;
    logic [1:0] win_lvl;
    logic [1:0] lvl_i;
    logic act_found;
    logic [1:0] act_lvl;
    logic wr_seen_q;
    logic blocked;
    logic may_call;

    always_comb begin
        win_found = 1'b0;
        win_src = 4'h0;
        win_lvl = 2'h0;
        lvl_i = 2'h0;
        for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
            lvl_i = {hi[i], lo[i]}; // R3
            // R1 R8 R12
            if (req[i] && en[i] && en_main_q[pic_pkg::GLOBAL_EN_BIT]) begin
                // strict compare keeps earlier source on a tie R7
                if (!win_found || (lvl_i > win_lvl)) begin
                    win_found = 1'b1;
                    win_src = 4'(i);
                    win_lvl = lvl_i;
                end
            end
        end
    end

    always_comb begin
        act_found = 1'b0;
        act_lvl = 2'h0;
        for (int l = 0; l < pic_pkg::NUM_LVL; l++) begin
            if (isr_q[l]) begin
                act_found = 1'b1;
                act_lvl = 2'(l);
            end
        end
    end

    // register writes during the instruction hold off the call
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_seen_q <= 1'b0;
        end else if (irq_reg_wr) begin
            wr_seen_q <= 1'b1; // R11
        end else if (tick_q && last_cycle_in) begin
            wr_seen_q <= 1'b0;
        end
    end

    assign blocked = wr_seen_q || irq_reg_wr || irq_exit_instr_in; // R11
    // R6 R9 R10
    assign may_call = tick_q && last_cycle_in && !blocked && win_found &&
                      (!act_found || (win_lvl > act_lvl));

    //******************************************************************
    // in-service tracking
    //******************************************************************
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            isr_q <= 4'h0;
        end else if (may_call) begin
            isr_q[win_lvl] <= 1'b1; // R20
        end else if (tick_q && last_cycle_in && irq_exit_instr_in && act_found) begin
            isr_q[act_lvl] <= 1'b0; // R18 R19 R20
        end
    end

    //******************************************************************
    // call and flag clearing
    //******************************************************************
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_call_out <= 1'b0;
            vector_addr_out <= 16'h0000;
            flag_clr_out <= '0;
        end else begin
            irq_call_out <= may_call; // R16
            flag_clr_out.timer0_clr <= may_call && (win_src == 4'(pic_pkg::SRC_TMR0)); // R13
            flag_clr_out.timer1_clr <= may_call && (win_src == 4'(pic_pkg::SRC_TMR1)); // R13
            flag_clr_out.ext0_clr <= may_call && ext0_edge_in && (win_src == 4'(pic_pkg::SRC_EXT0)); // R14
            flag_clr_out.ext1_clr <= may_call && ext1_edge_in && (win_src == 4'(pic_pkg::SRC_EXT1)); // R14 R15
            if (may_call) begin
                vector_addr_out <= vec_of(win_src); // R16 R17
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mcycle_tick_out <= 1'b0;
            in_service_out <= 4'h0;
        end else begin
            mcycle_tick_out <= tick_q;
            in_service_out <= isr_q;
        end
    end

endmodule

// ---- rtl/pic_pkg.sv ----
// package: constants, types and register map of the priority interrupt controller
//**********************************************************************
// Behaviour
// R1 - global enable bit 7 gates every request
// R2 - main enable register holds seven source enables
// R3 - priority is upper bit and lower bit
// R4 - group1 upper priority bits, bits 7:6 reserved
// R5 - group1 lower priority bits, bits 7:6 reserved
// R6 - lower level never pre-empts running routine
// R7 - same level resolved by fixed thirteen-source order
// R8 - flags sampled and resolved every machine cycle
// R9 - no call if equal/higher level in service
// R10 - call only in instruction's final machine cycle
// R11 - no call on irq register write or exit
// R12 - requests are never latched by controller
// R13 - timer overflow flags cleared on vectoring
// R14 - external flags cleared only when edge-triggered
// R15 - serial and watchdog flags left for software
// R16 - call pushes pc without status, loads vector
// R17 - fixed vector address for each source
// R18 - interrupt exit ends current service routine
// R19 - plain subroutine exit keeps service state
// R20 - one in-service bit per priority level
//**********************************************************************
package pic_pkg;

    //******************************************************************
    // register map
    //******************************************************************
    localparam logic [7:0] ADDR_IRQ_EN_MAIN = 8'ha8;
    localparam logic [7:0] ADDR_IRQ_EN_AUX = 8'he8;
    localparam logic [7:0] ADDR_PRIO_LOW_G0 = 8'hb8;
    localparam logic [7:0] ADDR_PRIO_HIGH_G0 = 8'hb7;
    localparam logic [7:0] ADDR_PRIO_LOW_G1 = 8'hf8;
    localparam logic [7:0] ADDR_PRIO_HIGH_G1 = 8'hf7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RD_UNIMPL = 8'hff;
    localparam logic [7:0] G1_RSVD_MASK = 8'hc0;
    localparam int GLOBAL_EN_BIT = 7;

    //******************************************************************
    // timing
    //******************************************************************
    localparam int MCYCLE_CLKS = 4;
    localparam logic [1:0] MCYCLE_LAST = 2'h3;
    localparam int NUM_SRC = 13;
    localparam int NUM_LVL = 4;

    //******************************************************************
    // source order, highest first
    //******************************************************************
    localparam int SRC_EXT0 = 0;
    localparam int SRC_BOD = 1;
    localparam int SRC_WDT = 2;
    localparam int SRC_TMR0 = 3;
    localparam int SRC_TWI = 4;
    localparam int SRC_ADC = 5;
    localparam int SRC_EXT1 = 6;
    localparam int SRC_KBD = 7;
    localparam int SRC_CMP1 = 8;
    localparam int SRC_TMR1 = 9;
    localparam int SRC_CMP2 = 10;
    localparam int SRC_UART = 11;
    localparam int SRC_PWM = 12;

    typedef struct packed {
        logic pwm_brake_flag;
        logic uart_tx_done_flag;
        logic uart_rx_done_flag;
        logic comparator2_flag;
        logic timer1_overflow_flag;
        logic comparator1_flag;
        logic keypad_flag;
        logic ext1_irq_flag;
        logic converter_done_flag;
        logic twowire_flag;
        logic timer0_overflow_flag;
        logic watchdog_irq_flag;
        logic brownout_flag;
        logic ext0_irq_flag;
    } pic_flags_t;

    typedef struct packed {
        logic ext1_clr;
        logic ext0_clr;
        logic timer1_clr;
        logic timer0_clr;
    } pic_clr_t;

    typedef enum logic [1:0] {
        PIC_LVL0 = 2'h0,
        PIC_LVL1 = 2'h1,
        PIC_LVL2 = 2'h2,
        PIC_LVL3 = 2'h3
    } pic_lvl_t;

endpackage

// ---- rtl/pic_unused_placeholder_removed.sv ----
// module: none; intentionally empty file kept minimal
`timescale 1ns/10ps

// ---- sim/pic_ctrl_asserts.sv ----
// checker: port timing relations of the interrupt controller
`timescale 1ns/10ps
module pic_ctrl_asserts (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire pic_pkg::pic_flags_t flags_in,
    input wire logic ext0_edge_in,
    input wire logic ext1_edge_in,
    input wire logic last_cycle_in,
    input wire logic irq_exit_instr_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic sfr_hit_out,
    input wire logic mcycle_tick_out,
    input wire logic irq_call_out,
    input wire logic [15:0] vector_addr_out,
    input wire logic [3:0] in_service_out,
    input wire pic_pkg::pic_clr_t flag_clr_out
);
    //************
    // properties
    //************
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_call_on_tick: assert property (irq_call_out |-> mcycle_tick_out)
        else $error("call off machine cycle");
    a_call_last_cycle: assert property (irq_call_out |-> $past(last_cycle_in))
        else $error("call outside final cycle");
    a_exit_blocks_call: assert property (irq_call_out |-> !$past(irq_exit_instr_in))
        else $error("call during exit");
    a_call_once: assert property (irq_call_out |=> !irq_call_out [*3])
        else $error("two calls in one cycle");
    a_clr_with_call: assert property ((flag_clr_out != 4'h0) |-> irq_call_out)
        else $error("clear without call");
    a_timer0_clr: assert property (irq_call_out && vector_addr_out == 16'h000b |-> flag_clr_out == 4'h1)
        else $error("timer0 flag not cleared");
    a_ext0_level: assert property (flag_clr_out.ext0_clr |-> $past(ext0_edge_in))
        else $error("level flag cleared");
    a_sw_flags_kept: assert property (irq_call_out && (vector_addr_out == 16'h0023
        || vector_addr_out == 16'h0053) |-> flag_clr_out == 4'h0)
        else $error("software flag cleared");
    a_service_set: assert property ((in_service_out & ~$past(in_service_out)) != 4'h0
        |-> $past(irq_call_out))
        else $error("service set without call");
    a_service_end: assert property ((~in_service_out & $past(in_service_out)) != 4'h0
        |-> $past(irq_exit_instr_in, 2))
        else $error("service ended without exit");
    a_vector_hold: assert property ($changed(vector_addr_out) |-> irq_call_out)
        else $error("vector moved without call");
    a_rd_unmapped: assert property (sfr_rd_in && sfr_addr_in == 8'h00
        |=> !sfr_hit_out && sfr_rdata_out == 8'hff)
        else $error("unmapped read answered");
endmodule

bind pic_ctrl pic_ctrl_asserts i_pic_ctrl_asserts (.ref_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wdata_in,
    .sfr_wr_in, .sfr_rd_in, .flags_in, .ext0_edge_in, .ext1_edge_in, .last_cycle_in, .irq_exit_instr_in,
    .sfr_rdata_out, .sfr_hit_out, .mcycle_tick_out, .irq_call_out, .vector_addr_out, .in_service_out,
    .flag_clr_out);

// ---- sim/pic_ctrl_bench.sv ----
// testbench: registers, vectors, priorities and returns of the interrupt controller
`timescale 1ns/10ps
module pic_ctrl_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic last = 1'b0;
    logic ex = 1'b0;
    logic e0 = 1'b0;
    logic e1 = 1'b1;
    logic [13:0] set = 14'h0000;
    logic [13:0] swclr = 14'h0000;
    pic_pkg::pic_flags_t flags;
    pic_pkg::pic_clr_t clr;
    logic [7:0] rdata;
    logic hit;
    logic tick;
    logic call;
    logic [15:0] vec;
    logic [15:0] lastv = 16'h0000;
    logic [3:0] insvc;
    int mismatches = 0;
    int check_count = 0;
    logic [15:0] vtab [13] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033, 16'h005b, 16'h0013,
        16'h003b, 16'h0063, 16'h001b, 16'h0043, 16'h0023, 16'h0073};
    logic [3:0] ctab [13] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0};

    always #50 clk = ~clk;

    pic_ctrl i_pic_ctrl (.ref_clk_in(clk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .flags_in(flags), .ext0_edge_in(e0), .ext1_edge_in(e1),
        .last_cycle_in(last), .irq_exit_instr_in(ex), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
        .mcycle_tick_out(tick), .irq_call_out(call), .vector_addr_out(vec), .in_service_out(insvc),
        .flag_clr_out(clr));
    pic_flag_model i_pic_flag_model (.clk_in(clk), .rst_n_in(rst_n), .set_in(set), .swclr_in(swclr),
        .hwclr_in(clr), .flags_out(flags));

    //************
    // tasks
    //************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] d, input logic h);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({23'h0, hit, rdata}, {23'h0, h, d});
    endtask

    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 20);
        if (tick !== 1'b1)
            mismatches++;
    endtask

    // one machine cycle: raise or clear flags, hold core state, compare call and service state
    task automatic mc(input logic [13:0] s, input logic [13:0] c, input logic lc, input logic e,
        input logic ec, input logic [15:0] ev, input logic [3:0] ecl, input logic [3:0] eis);
        logic c_call;
        logic [3:0] c_clr;
        logic [15:0] c_vec;
        wait_tick();
        @(posedge clk);
        set <= s;
        swclr <= c;
        last <= lc;
        ex <= e;
        @(posedge clk);
        set <= 14'h0000;
        swclr <= 14'h0000;
        wait_tick();
        if (ec)
            lastv = ev;
        c_call = call;
        c_clr = clr;
        c_vec = vec;
        @(posedge clk);
        last <= 1'b0;
        ex <= 1'b0;
        #1;
        check({7'h00, c_call, c_clr, insvc, c_vec}, {7'h00, ec, ecl, eis, lastv});
    endtask

    function automatic logic [13:0] msk(input int i);
        if (i < 11)
            return 14'h0001 << i;
        if (i == 11)
            return 14'h1800;
        return 14'h2000;
    endfunction

    //************
    // sequence
    //************
    initial begin
        #500000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'ha8, 8'h00, 1'b1);
        rd_chk(8'hf7, 8'hc0, 1'b1);
        rd_chk(8'hf8, 8'hc0, 1'b1);
        rd_chk(8'h00, 8'hff, 1'b0);
        wr_reg(8'hf7, 8'h2a);
        wr_reg(8'hf8, 8'h15);
        rd_chk(8'hf7, 8'hea, 1'b1);
        rd_chk(8'hf8, 8'hd5, 1'b1);
        wr_reg(8'hf7, 8'h00);
        wr_reg(8'hf8, 8'h00);
        wr_reg(8'ha8, 8'h02);
        mc(14'h0008, 14'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        mc(14'h0000, 14'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        wr_reg(8'ha8, 8'h82);
        mc(14'h0000, 14'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        mc(14'h0000, 14'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        mc(14'h0000, 14'h0000, 1'b1, 1'b0, 1'b1, 16'h000b, 4'h1, 4'h1);
        mc(14'h0000, 14'h0000, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h0, 4'h0);
        check({18'h0, flags}, 32'h0);
        mc(14'h0008, 14'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        mc(14'h0000, 14'h0008, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        wr_reg(8'ha8, 8'hff);
        wr_reg(pic_pkg::ADDR_IRQ_EN_AUX, 8'h3f);
        mc(14'h3fff, 14'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        for (int i = 0; i < 13; i++) begin
            mc(14'h0000, 14'h0000, 1'b1, 1'b0, 1'b1, vtab[i], ctab[i], 4'h1);
            mc(14'h0000, msk(i), 1'b1, 1'b1, 1'b0, 16'h0000, 4'h0, 4'h0);
        end
        @(posedge clk);
        e0 <= 1'b1;
        e1 <= 1'b0;
        mc(14'h0041, 14'h0000, 1'b1, 1'b0, 1'b1, 16'h0003, 4'h4, 4'h1);
        mc(14'h0000, 14'h0000, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h0, 4'h0);
        check({18'h0, flags}, 32'h40);
        mc(14'h0000, 14'h0000, 1'b1, 1'b0, 1'b1, 16'h0013, 4'h0, 4'h1);
        mc(14'h0000, 14'h0040, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h0, 4'h0);
        wr_reg(pic_pkg::ADDR_PRIO_LOW_G0, 8'h02);
        wr_reg(8'hf7, 8'h02);
        wr_reg(8'hf8, 8'h06);
        mc(14'h0008, 14'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h0);
        mc(14'h0000, 14'h0000, 1'b1, 1'b0, 1'b1, 16'h000b, 4'h1, 4'h2);
        mc(14'h2100, 14'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h2);
        mc(14'h0080, 14'h0000, 1'b1, 1'b0, 1'b1, 16'h003b, 4'h0, 4'ha);
        mc(14'h0000, 14'h0080, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h0, 4'h2);
        mc(14'h0000, 14'h0000, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h0, 4'h0);
        mc(14'h0000, 14'h0000, 1'b1, 1'b0, 1'b1, 16'h0063, 4'h0, 4'h2);
        stop_test();
    end
endmodule

// ---- sim/pic_flag_model.sv ----
// model: peripheral flag sources, set by stimulus, cleared by software or on vectoring
`timescale 1ns/10ps
module pic_flag_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [13:0] set_in,
    input wire logic [13:0] swclr_in,
    input wire pic_pkg::pic_clr_t hwclr_in,
    output pic_pkg::pic_flags_t flags_out
);
    logic [13:0] hw;
    assign hw = {4'h0, hwclr_in.timer1_clr, 2'h0, hwclr_in.ext1_clr, 2'h0, hwclr_in.timer0_clr, 2'h0,
        hwclr_in.ext0_clr};
    // flags stay up until cleared; serial and watchdog only by software
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_out <= 14'h0000;
        end else begin
            flags_out <= (flags_out & ~swclr_in & ~hw) | set_in;
        end
    end
endmodule
